// File: sim/shr_host_model.sv
/*
 * host side model: takes reply characters and stores them.
 * assumes one reporter driving chr_valid, chr_data and chr_last.
 */
`timescale 1ns/10ps
module shr_host_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic slow,
	input wire logic clr,
	input wire logic chr_valid,
	input wire logic [7:0] chr_data,
	input wire logic chr_last,
	output logic chr_ready,
	output logic done,
	output logic [7:0] rx [32],
	output logic [5:0] rx_len
);
	// ****************************************
	// acceptance
	// ****************************************
	logic tick;
	wire logic take = chr_valid & chr_ready & ~clr;
	// slow mode stalls every other cycle
	assign chr_ready = ~slow | tick;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tick <= 1'b0;
			done <= 1'b0;
			rx_len <= 6'h00;
		end else begin
			tick <= ~tick;
			if (clr) begin
				done <= 1'b0;
				rx_len <= 6'h00;
			end else if (take) begin
				rx_len <= rx_len + 6'h01;
				done <= chr_last;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (take) begin
			rx[rx_len[4:0]] <= chr_data;
		end
	end
endmodule

// File: sim/tb.sv
/*
 * testbench for the status and header reporter.
 * assumes shr_reporter and shr_host_model are compiled beforehand.
 */
`timescale 1ns/10ps
module tb;
	import shr_pkg::*;
	// ****************************************
	// set-up
	// ****************************************
	localparam int TVL = 4;
	localparam string FN = "AC-DC-REFATTFRQDCFZ  SL_SR_CV1CF1CV2CF2";
	localparam string UN = "V  W  DBUDBMDB-HZ_OHM";
	localparam string IDC = " !HLAF1xE";
	localparam logic [7:0] ID_IN [9] = '{8'h00, 8'h01, 8'h0A, 8'h0C, 8'h80, 8'h88, 8'h30,
		8'h20, 8'h40};
	logic clk, rst_b, cmd_valid, header_en, cal_update, chr_ready, chr_valid, chr_last;
	logic slow, clr, done, cmd_ready;
	shr_cmd_e cmd_code;
	shr_func_e func_code;
	shr_unit_e unit_code;
	logic [87:0] value_text;
	logic [8*TVL-1:0] tv_text;
	logic [5:0] idv;
	logic [1:0] lf;
	logic [4:0] ev;
	logic [3:0] sf;
	logic [63:0] hw, hw_word;
	logic [7:0] cal_result, chr_data, glob, cal_view, ser_view;
	logic [7:0] rx [32];
	logic [5:0] rx_len;
	int err_total, samples_checked;
	shr_reporter #(.TV_LEN(TVL)) shr_reporter_inst (.clk(clk), .rst_b(rst_b),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .func_code(func_code),
		.unit_code(unit_code), .header_en(header_en), .value_text(value_text),
		.overload(idv[0]), .value_beyond_right(idv[1]), .value_beyond_left(idv[2]),
		.scale_fixed(idv[3]), .on_battery(idv[4]), .battery_model(idv[5]),
		.tested_value_text(tv_text), .probe_fault(lf[0]), .cal_checksum_fault(lf[1]),
		.serial_error_event(ev[0]), .zeroing_fault(ev[1]), .entry_range_fault(ev[2]),
		.offset_cal_fault(ev[3]), .cal_factor_fault(ev[4]), .hw_fault_in(hw),
		.cal_update(cal_update), .cal_result(cal_result), .illegal_command_fault(sf[0]),
		.empty_recall_fault(sf[1]), .write_protect_fault(sf[2]),
		.unparsed_command_fault(sf[3]), .cmd_ready(cmd_ready), .chr_valid(chr_valid),
		.chr_data(chr_data), .chr_last(chr_last), .chr_ready(chr_ready),
		.global_error_byte(glob), .hardware_error_word(hw_word),
		.calibration_checksum_errors(cal_view), .serial_error_byte(ser_view));
	shr_host_model shr_host_model_inst (.clk(clk), .rst_b(rst_b), .slow(slow), .clr(clr),
		.chr_valid(chr_valid), .chr_data(chr_data), .chr_last(chr_last),
		.chr_ready(chr_ready), .done(done), .rx(rx), .rx_len(rx_len));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ****************************************
	// tasks
	// ****************************************
	task automatic summarize;
		$display("counts: %0d checked, %0d mismatches", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic run_cmd(input shr_cmd_e c);
		int n;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		clr <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		clr <= 1'b0;
		#1;
		n = 0;
		while (done !== 1'b1 && n < 300) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(done, 1'b1);
	endtask
	task automatic chk_hex(input int n, input logic [63:0] v);
		logic [3:0] nb;
		chk(rx_len, n);
		for (int i = 0; i < n; i++) begin
			nb = v[4*(n-1-i) +: 4];
			chk(rx[i], nb < 4'hA ? 8'h30 + nb : 8'h37 + nb);
		end
	endtask
	task automatic chk_str(input string s, input int off);
		for (int i = 0; i < s.len(); i++) chk(rx[off+i], s[i]);
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial begin
		#400000;
		err_total++;
		summarize();
	end
	initial begin
		rst_b = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = SHR_CMD_GLOBAL;
		func_code = SHR_FN_AC;
		unit_code = SHR_UN_V;
		header_en = 1'b1;
		value_text = "-1.4142E+01";
		tv_text = "T=12";
		{idv, lf, ev, sf, hw, cal_update, cal_result, slow, clr} = '0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		run_cmd(SHR_CMD_GLOBAL);
		chk_hex(2, 8'h00);
		chk(cmd_ready, 1'b1);
		@(posedge clk);
		lf <= 2'b11;
		ev <= 5'h1F;
		sf <= 4'hF;
		@(posedge clk);
		ev <= 5'h00;
		sf <= 4'h0;
		slow <= 1'b1;
		#1;
		chk(glob, 8'hFD);
		chk(ser_view, 8'h0F);
		run_cmd(SHR_CMD_GLOBAL);
		chk_hex(2, 8'hFD);
		run_cmd(SHR_CMD_GLOBAL);
		chk_hex(2, 8'h05);
		run_cmd(SHR_CMD_SER);
		chk_hex(2, 8'h0F);
		run_cmd(SHR_CMD_SER);
		chk_hex(2, 8'h00);
		chk(ser_view, 8'h00);
		$display("test error bytes done");
		hw <= '1;
		run_cmd(SHR_CMD_HW);
		chk_hex(16, 64'h0283_8000_07FF_E7E0);
		chk(hw_word, 64'h0283_8000_07FF_E7E0);
		run_cmd(SHR_CMD_GLOBAL);
		chk_hex(2, 8'h07);
		hw <= 64'h0280_0000_0000_001F;
		run_cmd(SHR_CMD_HW);
		chk_hex(16, 64'h0200_0000_0000_0000);
		chk(hw_word, 64'h0200_0000_0000_0000);
		chk(glob, 8'h05);
		cal_update <= 1'b1;
		cal_result <= 8'hFF;
		@(posedge clk);
		cal_update <= 1'b0;
		cal_result <= 8'h0A;
		run_cmd(SHR_CMD_CAL);
		chk_hex(2, 8'h1F);
		chk(cal_view, 8'h1F);
		$display("test hardware and calibration done");
		hw <= 64'h0;
		for (int i = 0; i < 13; i++) begin
			func_code <= shr_func_e'(i);
			unit_code <= shr_unit_e'(i % 7);
			run_cmd(SHR_CMD_VALUE);
			chk(rx_len, 18);
			chk_str(FN.substr(3*i, 3*i+2), 0);
			chk_str(UN.substr(3*(i%7), 3*(i%7) + ((i%7 < 2) ? 0 : 2)), 3);
			chk(rx[6], (i == 7 || i == 8) ? "A" : " ");
			chk_str("-1.4142E+01", 7);
		end
		for (int i = 0; i < 9; i++) begin
			idv <= ID_IN[i][5:0];
			hw <= ID_IN[i][6] ? 64'h20 : 64'h0;
			func_code <= ID_IN[i][7] ? SHR_FN_SL : SHR_FN_AC;
			run_cmd(SHR_CMD_VALUE);
			chk(rx[6], IDC[i]);
		end
		$display("test header done");
		header_en <= 1'b0;
		run_cmd(SHR_CMD_VALUE);
		chk(rx_len, 11);
		chk_str("-1.4142E+01", 0);
		run_cmd(SHR_CMD_TV);
		chk(rx_len, TVL);
		chk_str("T=12", 0);
		$display("test plain and tested value done");
		@(posedge clk);
		ev <= 5'h1F;
		@(posedge clk);
		ev <= 5'h00;
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk(glob, 8'h07);
		chk(ser_view, 8'h00);
		chk(cal_view, 8'h00);
		chk(cmd_ready, 1'b1);
		run_cmd(SHR_CMD_GLOBAL);
		chk_hex(2, 8'h07);
		$display("test reset done");
		summarize();
	end
endmodule

// File: src/shr_hex_digit.sv
/*
 * converts one nibble to an upper-case ascii hex digit.
 * purely combinational; caller registers the result.
 */
`timescale 1ns/10ps
module shr_hex_digit (
	input wire logic [3:0] nib,
	output logic [7:0] chr
);
	// digits 0-9 then A-F
	assign chr = (nib < 4'hA) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
endmodule

// File: src/shr_pkg.sv
/*
 * types for the status and header reporter.
 * does not use shr_regs.svh; numeric constants are written here as literals.
 */
package shr_pkg;
	typedef enum logic [2:0] {
		SHR_CMD_GLOBAL = 3'h0,
		SHR_CMD_HW = 3'h1,
		SHR_CMD_CAL = 3'h2,
		SHR_CMD_SER = 3'h3,
		SHR_CMD_TV = 3'h4,
		SHR_CMD_VALUE = 3'h5
	} shr_cmd_e;
	typedef enum logic [3:0] {
		SHR_FN_AC = 4'h0, SHR_FN_DC = 4'h1, SHR_FN_REF = 4'h2, SHR_FN_ATT = 4'h3,
		SHR_FN_FRQ = 4'h4, SHR_FN_DCF = 4'h5, SHR_FN_Z = 4'h6, SHR_FN_SL = 4'h7,
		SHR_FN_SR = 4'h8, SHR_FN_CV1 = 4'h9, SHR_FN_CF1 = 4'hA, SHR_FN_CV2 = 4'hB,
		SHR_FN_CF2 = 4'hC
	} shr_func_e;
	typedef enum logic [2:0] {
		SHR_UN_V = 3'h0, SHR_UN_W = 3'h1, SHR_UN_DBU = 3'h2, SHR_UN_DBM = 3'h3,
		SHR_UN_DB = 3'h4, SHR_UN_HZ = 3'h5, SHR_UN_OHM = 3'h6
	} shr_unit_e;
	typedef enum logic [1:0] {
		SHR_ST_IDLE = 2'h0,
		SHR_ST_SEND = 2'h1
	} shr_state_e;
endpackage

// File: src/shr_regs.svh
/*
 * register layout, hardware bit positions and reply lengths for the
 * status and header reporter. assumes nothing beyond inclusion.
 */
`ifndef SHR_REGS_SVH
`define SHR_REGS_SVH
`define SHR_GLOB_STICKY_MASK 8'hF8
`define SHR_GLOB_LIVE_MASK 8'h07
`define SHR_HW_SUMMARY_BIT 55
`define SHR_HW_BATT_BIT 57
`define SHR_HW_VALID_MASK 64'h0203_8000_07FF_E7E0
`define SHR_CAL_VALID_MASK 8'h1F
`define SHR_SER_VALID_MASK 8'h0F
`define SHR_HDR_LEN 7
`define SHR_VAL_LEN 11
`define SHR_HEX_BYTE_LEN 2
`define SHR_HEX_WORD_LEN 16
`define SHR_TV_LEN 24
`endif

// File: src/shr_reporter.sv
/*
 * status and header reporter: builds alphaheader replies for output
 * queries and returns the error status registers as ascii hex, one
 * character per handshake. assumes a command parser upstream that
 * pulses cmd_valid with a decoded command and a serialiser downstream
 * that takes characters on chr_valid and chr_ready.
 */
// Function
// - output queries may carry a prefixed header
// - function field is three-character function code
// - unit field encodes the value unit
// - special id blank, overload or hardware error
// - fixed scale overrange gives H or L
// - scale limit value gives A or F
// - battery model gives 1 or x
// - four read commands return four error registers
// - each byte sent as two upper-case hex
// - global byte bit layout as listed
// - global bits 3-7 sticky, cleared by read
// - global bits 0-2 follow live condition
// - hardware word returned as sixteen hex characters
// - hardware bit 55 is OR of 0-54
// - battery bit 57 independent of summary
// - reserved hardware bits read zero
// - hardware bits placed at documented positions
// - tested value query returns value and tolerance
// - calibration byte bits 0-4, rest reserved
// - calibration bits change only on init or calibration
// - serial error byte bits 0-3, cleared by read
`timescale 1ns/10ps
`include "shr_regs.svh"
module shr_reporter #(
	parameter int TV_LEN = `SHR_TV_LEN
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cmd_valid,
	input wire shr_pkg::shr_cmd_e cmd_code,
	input wire shr_pkg::shr_func_e func_code,
	input wire shr_pkg::shr_unit_e unit_code,
	input wire logic header_en,
	input wire logic [8*`SHR_VAL_LEN-1:0] value_text,
	input wire logic overload,
	input wire logic value_beyond_right,
	input wire logic value_beyond_left,
	input wire logic scale_fixed,
	input wire logic battery_model,
	input wire logic on_battery,
	input wire logic [8*TV_LEN-1:0] tested_value_text,
	input wire logic probe_fault,
	input wire logic cal_checksum_fault,
	input wire logic serial_error_event,
	input wire logic zeroing_fault,
	input wire logic entry_range_fault,
	input wire logic offset_cal_fault,
	input wire logic cal_factor_fault,
	input wire logic [63:0] hw_fault_in,
	input wire logic cal_update,
	input wire logic [7:0] cal_result,
	input wire logic illegal_command_fault,
	input wire logic empty_recall_fault,
	input wire logic write_protect_fault,
	input wire logic unparsed_command_fault,
	output logic cmd_ready,
	output logic chr_valid,
	output logic [7:0] chr_data,
	output logic chr_last,
	input wire logic chr_ready,
	output logic [7:0] global_error_byte,
	output logic [63:0] hardware_error_word,
	output logic [7:0] calibration_checksum_errors,
	output logic [7:0] serial_error_byte
);
	import shr_pkg::*;
	localparam int BUF_LEN = `SHR_HDR_LEN + TV_LEN + `SHR_HEX_WORD_LEN;

	// ****************************************************************
	// error registers
	// ****************************************************************
	logic [4:0] glob_sticky;
	logic [7:0] cal_reg;
	logic [3:0] ser_reg;
	logic rd_global;
	logic rd_serial;
	logic [63:0] hw_masked;
	logic hw_summary;
	logic [4:0] glob_events;
	logic [3:0] ser_events;

	assign hw_masked = hw_fault_in & `SHR_HW_VALID_MASK;
	assign hw_summary = |hw_masked[54:0];
	// battery bit passes through unaffected by the summary
	assign hardware_error_word = {hw_masked[63:56], hw_summary, hw_masked[54:0]};
	assign glob_events = {cal_factor_fault, offset_cal_fault, entry_range_fault,
		zeroing_fault, serial_error_event};
	assign ser_events = {unparsed_command_fault, write_protect_fault, empty_recall_fault,
		illegal_command_fault};
	assign global_error_byte = {glob_sticky, cal_checksum_fault, hw_summary, probe_fault};
	assign calibration_checksum_errors = cal_reg;
	assign serial_error_byte = {4'h0, ser_reg};
	assign rd_global = cmd_valid && cmd_ready && cmd_code == SHR_CMD_GLOBAL;
	assign rd_serial = cmd_valid && cmd_ready && cmd_code == SHR_CMD_SER;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			glob_sticky <= 5'h00;
			ser_reg <= 4'h0;
			cal_reg <= 8'h00;
		end else begin
			// new events win over the clear-on-read
			glob_sticky <= (rd_global ? 5'h00 : glob_sticky) | glob_events;
			ser_reg <= (rd_serial ? 4'h0 : ser_reg) | ser_events;
			if (cal_update) begin
				cal_reg <= cal_result & `SHR_CAL_VALID_MASK;
			end
		end
	end

	// ****************************************************************
	// special identification and header
	// ****************************************************************
	logic [7:0] spec_id;
	logic [23:0] func_chars;
	logic [23:0] unit_chars;
	logic is_limit;

	assign is_limit = func_code == SHR_FN_SL || func_code == SHR_FN_SR;
	assign spec_id = is_limit ? (scale_fixed ? 8'h46 : 8'h41) :
		hw_summary ? 8'h45 :
		overload ? 8'h21 :
		(scale_fixed && value_beyond_right) ? 8'h48 :
		(scale_fixed && value_beyond_left) ? 8'h4C :
		battery_model ? (on_battery ? 8'h31 : 8'h78) :
		8'h20;

	always_comb begin
		case (func_code)
			SHR_FN_AC: func_chars = 24'h41432D;
			SHR_FN_DC: func_chars = 24'h44432D;
			SHR_FN_REF: func_chars = 24'h524546;
			SHR_FN_ATT: func_chars = 24'h415454;
			SHR_FN_FRQ: func_chars = 24'h465251;
			SHR_FN_DCF: func_chars = 24'h444346;
			SHR_FN_Z: func_chars = 24'h5A2020;
			SHR_FN_SL: func_chars = 24'h534C5F;
			SHR_FN_SR: func_chars = 24'h53525F;
			SHR_FN_CV1: func_chars = 24'h435631;
			SHR_FN_CF1: func_chars = 24'h434631;
			SHR_FN_CV2: func_chars = 24'h435632;
			SHR_FN_CF2: func_chars = 24'h434632;
			default: func_chars = 24'h3F3F3F;
		endcase
	end

	always_comb begin
		case (unit_code)
			SHR_UN_V: unit_chars = 24'h562020;
			SHR_UN_W: unit_chars = 24'h572020;
			SHR_UN_DBU: unit_chars = 24'h444255;
			SHR_UN_DBM: unit_chars = 24'h44424D;
			SHR_UN_DB: unit_chars = 24'h44422D;
			SHR_UN_HZ: unit_chars = 24'h485A5F;
			SHR_UN_OHM: unit_chars = 24'h4F484D;
			default: unit_chars = 24'h3F3F3F;
		endcase
	end

	// ****************************************************************
	// hex conversion
	// ****************************************************************
	logic [63:0] hex_src;
	logic [8*`SHR_HEX_WORD_LEN-1:0] hex_chars;

	assign hex_src = (cmd_code == SHR_CMD_HW) ? hardware_error_word :
		(cmd_code == SHR_CMD_CAL) ? {56'h0, calibration_checksum_errors} :
		(cmd_code == SHR_CMD_SER) ? {56'h0, serial_error_byte} :
		{56'h0, global_error_byte};

	genvar gi;
	generate
		for (gi = 0; gi < `SHR_HEX_WORD_LEN; gi++) begin : g_hex
			shr_hex_digit u_dig (
				.nib(hex_src[4*gi +: 4]),
				.chr(hex_chars[8*gi +: 8])
			);
		end
	endgenerate

	// ****************************************************************
	// reply sequencer, first character in the top byte
	// ****************************************************************
	shr_state_e state;
	logic [8*BUF_LEN-1:0] buf_q;
	logic [7:0] remain;
	logic [8*BUF_LEN-1:0] next_buf;
	logic [7:0] next_len;
	logic [8*`SHR_VAL_LEN-1:0] value_part;
	logic [8*BUF_LEN-1:0] value_reply;

	localparam int PAD = BUF_LEN - `SHR_HDR_LEN - `SHR_VAL_LEN;
	assign value_part = value_text;
	assign value_reply = header_en ?
		{func_chars, unit_chars, spec_id, value_part, {PAD{8'h20}}} :
		{value_part, {(BUF_LEN - `SHR_VAL_LEN){8'h20}}};

	always_comb begin
		next_buf = '0;
		next_len = 8'h00;
		case (cmd_code)
			SHR_CMD_HW: begin
				next_buf[8*BUF_LEN-1 -: 8*`SHR_HEX_WORD_LEN] = hex_chars;
				next_len = 8'(`SHR_HEX_WORD_LEN);
			end
			SHR_CMD_GLOBAL, SHR_CMD_CAL, SHR_CMD_SER: begin
				next_buf[8*BUF_LEN-1 -: 16] = hex_chars[15:0];
				next_len = 8'(`SHR_HEX_BYTE_LEN);
			end
			SHR_CMD_TV: begin
				next_buf[8*BUF_LEN-1 -: 8*TV_LEN] = tested_value_text;
				next_len = 8'(TV_LEN);
			end
			SHR_CMD_VALUE: begin
				next_buf = value_reply;
				next_len = header_en ? 8'(`SHR_HDR_LEN + `SHR_VAL_LEN) : 8'(`SHR_VAL_LEN);
			end
			default: begin
				next_buf = '0;
				next_len = 8'h00;
			end
		endcase
	end

	assign cmd_ready = state == SHR_ST_IDLE;
	assign chr_valid = state == SHR_ST_SEND;
	assign chr_data = buf_q[8*BUF_LEN-1 -: 8];
	assign chr_last = chr_valid && remain == 8'h01;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= SHR_ST_IDLE;
			buf_q <= '0;
			remain <= 8'h00;
		end else begin
			case (state)
				SHR_ST_IDLE: begin
					if (cmd_valid && next_len != 8'h00) begin
						buf_q <= next_buf;
						remain <= next_len;
						state <= SHR_ST_SEND;
					end
				end
				SHR_ST_SEND: begin
					if (chr_ready) begin
						buf_q <= {buf_q[8*BUF_LEN-9:0], 8'h00};
						remain <= remain - 8'h01;
						if (remain == 8'h01) begin
							state <= SHR_ST_IDLE;
						end
					end
				end
				default: state <= SHR_ST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	sequence s_global_read;
		cmd_valid && cmd_ready && cmd_code == SHR_CMD_GLOBAL;
	endsequence

	a_sticky_clear: assert property (@(posedge clk) disable iff (!rst_b)
		s_global_read ##0 (glob_events == 5'h00) |=> glob_sticky == 5'h00)
		else $error("global sticky bits not cleared by read");
	a_sticky_hold: assert property (@(posedge clk) disable iff (!rst_b)
		!rd_global |=> ((glob_sticky & $past(glob_sticky)) == $past(glob_sticky)))
		else $error("global sticky bit lost without read");
	a_live_bits: assert property (@(posedge clk) disable iff (!rst_b)
		global_error_byte[0] == probe_fault && global_error_byte[2] == cal_checksum_fault)
		else $error("live global bits do not follow condition");
	a_hw_summary: assert property (@(posedge clk) disable iff (!rst_b)
		hardware_error_word[55] == |hardware_error_word[54:0])
		else $error("summary bit wrong");
	a_hw_reserved: assert property (@(posedge clk) disable iff (!rst_b)
		(hardware_error_word & ~(`SHR_HW_VALID_MASK | 64'h0080_0000_0000_0000)) == 64'h0)
		else $error("reserved hardware bit set");
	a_batt_bit: assert property (@(posedge clk) disable iff (!rst_b)
		hardware_error_word[57] == hw_fault_in[57])
		else $error("battery bit not independent");
	a_cal_hold: assert property (@(posedge clk) disable iff (!rst_b)
		!cal_update |=> $stable(cal_reg))
		else $error("calibration byte changed without update");
	a_ser_clear: assert property (@(posedge clk) disable iff (!rst_b)
		rd_serial && ser_events == 4'h0 |=> ser_reg == 4'h0)
		else $error("serial byte not cleared by read");
	a_hw_length: assert property (@(posedge clk) disable iff (!rst_b)
		(cmd_valid && cmd_ready && cmd_code == SHR_CMD_HW) |=> remain == 8'h10)
		else $error("hardware reply not sixteen characters");
	a_hex_digit: assert property (@(posedge clk) disable iff (!rst_b)
		(chr_valid && remain <= 8'h02 && $past(cmd_code) == SHR_CMD_GLOBAL && $past(cmd_ready))
		|-> ((chr_data >= 8'h30 && chr_data <= 8'h39) || (chr_data >= 8'h41 && chr_data <= 8'h46)))
		else $error("byte reply not upper-case hex");
endmodule
